// file: rtl/eeprc_nibble_rev.sv
// nibble bit-order reversal with a select
`timescale 1ns/1ps
module eeprc_nibble_rev (
  input  wire logic       rev,
  input  wire logic [3:0] din,
  output logic      [3:0] dout
);
  // bit 3 maps to 0, 2 to 1, 1 to 2, 0 to 3 when selected
  always_comb begin
    dout = din;
    if (rev) begin
      for (int i = 0; i < 4; i++) begin
        dout[i] = din[3 - i];
      end
    end
  end
endmodule

// file: rtl/eeprc_pkg.sv
// package: register offsets, field positions and reset values of page 2 block
package eeprc_pkg;
  // register numbers within the management register space
  localparam logic [4:0] REG_PAGE_SELECT     = 5'h1f;
  localparam logic [4:0] REG_ENERGY_CTRL     = 5'h11;
  localparam logic [4:0] REG_MAC_IF_CTRL     = 5'h14;
  localparam logic [4:0] REG_WAKE_ADDR_LOW   = 5'h15;
  localparam logic [4:0] REG_PAGED_FIRST     = 5'h10;
  localparam logic [4:0] REG_PAGED_LAST      = 5'h1e;
  // page-select values
  localparam logic [15:0] PAGE_STANDARD      = 16'h0000;
  localparam logic [15:0] PAGE_EXTENDED_TWO  = 16'h0002;
  // energy-efficient control field positions
  localparam int EEC_TE_ENABLE_BIT           = 15;
  localparam int EEC_LED_INV_LSB             = 10;
  localparam int EEC_LINK_UP_BIT             = 8;
  localparam int EEC_TX100_EEE_BIT           = 6;
  localparam int EEC_FORCE_LPI_BIT           = 4;
  localparam int EEC_INHIBIT_TX_LPI_BIT      = 3;
  localparam int EEC_INHIBIT_RX_LPI_BIT      = 2;
  // mac interface control field positions
  localparam int MIC_FAST_LINK_FAILURE_SECOND_GEN_BIT                = 15;
  localparam int MIC_SOF_BIT                 = 12;
  localparam int MIC_RXD_REV_BIT             = 7;
  localparam int MIC_RX_DELAY_LSB            = 4;
  localparam int MIC_TXD_REV_BIT             = 3;
  localparam int MIC_TX_DELAY_LSB            = 0;
  // reset values
  localparam logic [1:0]  RST_LED_INV        = 2'h0;
  localparam logic [2:0]  RST_CLK_DELAY      = 3'h0;
  localparam logic [15:0] RST_WAKE_ADDR_LOW  = 16'h0000;
  localparam logic [15:0] RST_PAGE_SELECT    = 16'h0000;
  // management access commands
  typedef enum logic [1:0] {
    EEPRC_CMD_IDLE  = 2'b00,
    EEPRC_CMD_READ  = 2'b01,
    EEPRC_CMD_WRITE = 2'b10
  } eeprc_cmd_t;
endpackage

// file: rtl/eeprc_regs.sv
// extended page 2 energy, mac interface and wake address registers
`timescale 1ns/1ps
module eeprc_regs
  import eeprc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        soft_rst,
  input  wire logic        mgmt_valid,
  input  wire logic        mgmt_write,
  input  wire logic [4:0]  mgmt_reg,
  input  wire logic [15:0] mgmt_wdata,
  output logic             mgmt_hit,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  input  wire logic        link_up_in,
  input  wire logic        speed_100_in,
  input  wire logic        eee_negotiated_in,
  input  wire logic [1:0]  led_raw,
  output logic      [1:0]  led_out,
  input  wire logic [3:0]  mac_txd,
  input  wire logic        mac_tx_lpi,
  output logic      [3:0]  line_txd,
  output logic             line_tx_lpi,
  input  wire logic [3:0]  line_rxd,
  input  wire logic        line_rx_lpi,
  output logic      [3:0]  mac_rxd,
  output logic             mac_rx_lpi,
  input  wire logic        sof_event_in,
  output logic             sof_out,
  input  wire logic        fast_link_failure_second_gen_event_in,
  output logic             fast_link_failure_second_gen,
  output logic             te_mode,
  output logic             test_packet_generator_lpi,
  output logic      [2:0]  rx_clk_delay,
  output logic      [2:0]  tx_clk_delay,
  output logic      [15:0] magic_packet_wake_addr_low
);
  // storage: sticky control bits, non-sticky fast_link_failure_second_gen enable, page select
  logic        te_en, next_te_en;
  logic [1:0]  led_inv, next_led_inv;
  logic        force_lpi, next_force_lpi;
  logic        inh_tx, next_inh_tx;
  logic        inh_rx, next_inh_rx;
  logic        fast_link_failure_second_gen_en, next_fast_link_failure_second_gen_en;
  logic        sof_en, next_sof_en;
  logic        rxd_rev, next_rxd_rev;
  logic        txd_rev, next_txd_rev;
  logic [2:0]  rx_dly, next_rx_dly;
  logic [2:0]  tx_dly, next_tx_dly;
  logic [15:0] wake_lo, next_wake_lo;
  logic [15:0] page, next_page;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic        link_s1, link_s2, spd_s1, spd_s2, eee_s1, eee_s2;
  logic        tx100_eee, tx100_eee_q;
  logic [3:0]  txd_rev_out, rxd_rev_out;

  // decode: is the register number paged to page 2 right now
  function automatic logic on_page2(input logic [4:0] r,
                                    input logic [15:0] pg);
    on_page2 = (pg == PAGE_EXTENDED_TWO) && (r >= REG_PAGED_FIRST)
               && (r <= REG_PAGED_LAST);
  endfunction

  // status pins come from other domains, so two flops before use
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_s1 <= 1'b0;
      link_s2 <= 1'b0;
      spd_s1  <= 1'b0;
      spd_s2  <= 1'b0;
      eee_s1  <= 1'b0;
      eee_s2  <= 1'b0;
    end else begin
      link_s1 <= link_up_in;
      link_s2 <= link_s1;
      spd_s1  <= speed_100_in;
      spd_s2  <= spd_s1;
      eee_s1  <= eee_negotiated_in;
      eee_s2  <= eee_s1;
    end
  end

  // eee in effect only with link up at 100 and eee agreed
  assign tx100_eee = link_s2 && spd_s2 && eee_s2;

  // next-state of the register file and read data
  always_comb begin
    next_te_en     = te_en;
    next_led_inv   = led_inv;
    next_force_lpi = force_lpi;
    next_inh_tx    = inh_tx;
    next_inh_rx    = inh_rx;
    next_fast_link_failure_second_gen_en   = fast_link_failure_second_gen_en;
    next_sof_en    = sof_en;
    next_rxd_rev   = rxd_rev;
    next_txd_rev   = txd_rev;
    next_rx_dly    = rx_dly;
    next_tx_dly    = tx_dly;
    next_wake_lo   = wake_lo;
    next_page      = page;
    next_rdata     = 16'h0000;
    next_rvalid    = mgmt_valid && !mgmt_write && mgmt_hit;
    // software reset clears only the non-sticky enable
    if (soft_rst) begin
      next_fast_link_failure_second_gen_en = 1'b0;
    end
    if (mgmt_valid && mgmt_write) begin
      if (mgmt_reg == REG_PAGE_SELECT) begin
        next_page = mgmt_wdata;
      end else if (on_page2(mgmt_reg, page)
                   && mgmt_reg == REG_ENERGY_CTRL) begin
        // read-only and reserved positions are simply not stored
        next_te_en     = mgmt_wdata[EEC_TE_ENABLE_BIT];
        next_led_inv   = mgmt_wdata[EEC_LED_INV_LSB +: 2];
        next_force_lpi = mgmt_wdata[EEC_FORCE_LPI_BIT];
        next_inh_tx    = mgmt_wdata[EEC_INHIBIT_TX_LPI_BIT];
        next_inh_rx    = mgmt_wdata[EEC_INHIBIT_RX_LPI_BIT];
      end else if (on_page2(mgmt_reg, page)
                   && mgmt_reg == REG_MAC_IF_CTRL) begin
        next_fast_link_failure_second_gen_en = mgmt_wdata[MIC_FAST_LINK_FAILURE_SECOND_GEN_BIT];
        next_sof_en  = mgmt_wdata[MIC_SOF_BIT];
        next_rxd_rev = mgmt_wdata[MIC_RXD_REV_BIT];
        next_rx_dly  = mgmt_wdata[MIC_RX_DELAY_LSB +: 3];
        next_txd_rev = mgmt_wdata[MIC_TXD_REV_BIT];
        next_tx_dly  = mgmt_wdata[MIC_TX_DELAY_LSB +: 3];
      end else if (on_page2(mgmt_reg, page)
                   && mgmt_reg == REG_WAKE_ADDR_LOW) begin
        next_wake_lo = mgmt_wdata;
      end
    end
    // read mux; unlisted bits stay zero
    if (mgmt_reg == REG_PAGE_SELECT) begin
      next_rdata = page;
    end else if (on_page2(mgmt_reg, page)
                 && mgmt_reg == REG_ENERGY_CTRL) begin
      next_rdata[EEC_TE_ENABLE_BIT]      = te_en;
      next_rdata[EEC_LED_INV_LSB +: 2]   = led_inv;
      next_rdata[EEC_LINK_UP_BIT]        = link_s2;
      next_rdata[EEC_TX100_EEE_BIT]      = tx100_eee_q;
      next_rdata[EEC_FORCE_LPI_BIT]      = force_lpi;
      next_rdata[EEC_INHIBIT_TX_LPI_BIT] = inh_tx;
      next_rdata[EEC_INHIBIT_RX_LPI_BIT] = inh_rx;
    end else if (on_page2(mgmt_reg, page)
                 && mgmt_reg == REG_MAC_IF_CTRL) begin
      next_rdata[MIC_FAST_LINK_FAILURE_SECOND_GEN_BIT]           = fast_link_failure_second_gen_en;
      next_rdata[MIC_SOF_BIT]            = sof_en;
      next_rdata[MIC_RXD_REV_BIT]        = rxd_rev;
      next_rdata[MIC_RX_DELAY_LSB +: 3]  = rx_dly;
      next_rdata[MIC_TXD_REV_BIT]        = txd_rev;
      next_rdata[MIC_TX_DELAY_LSB +: 3]  = tx_dly;
    end else if (on_page2(mgmt_reg, page)
                 && mgmt_reg == REG_WAKE_ADDR_LOW) begin
      next_rdata = wake_lo;
    end
  end

  // claim only this block's registers; others belong elsewhere
  assign mgmt_hit = (mgmt_reg == REG_PAGE_SELECT)
                    || (on_page2(mgmt_reg, page)
                        && (mgmt_reg == REG_ENERGY_CTRL
                            || mgmt_reg == REG_MAC_IF_CTRL
                            || mgmt_reg == REG_WAKE_ADDR_LOW));

  // only hardware reset restores sticky defaults
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      te_en       <= 1'b0;
      led_inv     <= RST_LED_INV;
      force_lpi   <= 1'b0;
      inh_tx      <= 1'b0;
      inh_rx      <= 1'b0;
      fast_link_failure_second_gen_en     <= 1'b0;
      sof_en      <= 1'b0;
      rxd_rev     <= 1'b0;
      txd_rev     <= 1'b0;
      rx_dly      <= RST_CLK_DELAY;
      tx_dly      <= RST_CLK_DELAY;
      wake_lo     <= RST_WAKE_ADDR_LOW;
      page        <= RST_PAGE_SELECT;
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
      tx100_eee_q <= 1'b0;
    end else begin
      te_en       <= next_te_en;
      led_inv     <= next_led_inv;
      force_lpi   <= next_force_lpi;
      inh_tx      <= next_inh_tx;
      inh_rx      <= next_inh_rx;
      fast_link_failure_second_gen_en     <= next_fast_link_failure_second_gen_en;
      sof_en      <= next_sof_en;
      rxd_rev     <= next_rxd_rev;
      txd_rev     <= next_txd_rev;
      rx_dly      <= next_rx_dly;
      tx_dly      <= next_tx_dly;
      wake_lo     <= next_wake_lo;
      page        <= next_page;
      mgmt_rdata  <= next_rdata;
      mgmt_rvalid <= next_rvalid;
      tx100_eee_q <= tx100_eee;
    end
  end

  // nibble reversal on both data directions
  eeprc_nibble_rev u_tx_rev (
    .rev  (txd_rev),
    .din  (mac_txd),
    .dout (txd_rev_out)
  );
  eeprc_nibble_rev u_rx_rev (
    .rev  (rxd_rev),
    .din  (line_rxd),
    .dout (rxd_rev_out)
  );

  // datapath and control outputs, registered for clean timing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      line_txd                     <= 4'h0;
      line_tx_lpi                  <= 1'b0;
      mac_rxd                      <= 4'h0;
      mac_rx_lpi                   <= 1'b0;
      led_out                      <= 2'h3;
      sof_out                      <= 1'b0;
      fast_link_failure_second_gen <= 1'b0;
      test_packet_generator_lpi    <= 1'b0;
    end else begin
      // forced lpi drops mac data entirely
      line_txd <= force_lpi ? 4'h0 : txd_rev_out;
      line_tx_lpi <= force_lpi
                     || (mac_tx_lpi && !(inh_tx && spd_s2));
      mac_rxd <= rxd_rev_out;
      mac_rx_lpi <= line_rx_lpi && !(inh_rx && spd_s2);
      // raw led is active high; default drives pins low when on
      led_out <= ~led_raw ^ led_inv;
      sof_out <= sof_en && sof_event_in;
      fast_link_failure_second_gen <= fast_link_failure_second_gen_en && fast_link_failure_second_gen_event_in;
      test_packet_generator_lpi <= force_lpi;
    end
  end

  assign te_mode = te_en;
  assign rx_clk_delay = rx_dly;
  assign tx_clk_delay = tx_dly;
  assign magic_packet_wake_addr_low = wake_lo;
endmodule

// file: verif/eeprc_mgr_model.sv
// station manager model issuing management register accesses
`timescale 1ns/1ps
module eeprc_mgr_model
  import eeprc_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             mgmt_valid,
  output logic             mgmt_write,
  output logic      [4:0]  mgmt_reg,
  output logic      [15:0] mgmt_wdata,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid
);
  initial begin
    mgmt_valid = 1'b0;
    mgmt_write = 1'b0;
    mgmt_reg   = 5'h00;
    mgmt_wdata = 16'h0000;
  end
  // one access, held across the taking edge; answer sampled after it
  task automatic access(input logic wr, input logic [4:0] r,
    input logic [15:0] d, output logic ok, output logic [15:0] q);
    @(posedge clk_sys);
    #1;
    mgmt_valid = 1'b1;
    mgmt_write = wr;
    mgmt_reg   = r;
    mgmt_wdata = d;
    @(posedge clk_sys);
    #1;
    // released lines show inverted values so stale data never passes
    mgmt_valid = 1'b0;
    mgmt_reg   = ~r;
    mgmt_wdata = ~d;
    ok         = mgmt_rvalid;
    q          = mgmt_rdata;
  endtask
  // page select: 2 opens the extended page, 0 the standard space
  task automatic page(input logic [15:0] p);
    logic        ok;
    logic [15:0] q;
    access(1'b1, REG_PAGE_SELECT, p, ok, q);
  endtask
endmodule

// file: verif/eeprc_regs_sva.sv
// checker: port-level properties of the page 2 register block
`timescale 1ns/1ps
module eeprc_regs_sva
  import eeprc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        soft_rst,
  input wire logic        mgmt_valid,
  input wire logic        mgmt_write,
  input wire logic [4:0]  mgmt_reg,
  input wire logic [15:0] mgmt_wdata,
  input wire logic        mgmt_hit,
  input wire logic        mgmt_rvalid,
  input wire logic [1:0]  led_raw,
  input wire logic [1:0]  led_out,
  input wire logic [3:0]  line_txd,
  input wire logic        line_tx_lpi,
  input wire logic [3:0]  line_rxd,
  input wire logic [3:0]  mac_rxd,
  input wire logic        fast_link_failure_second_gen_event_in,
  input wire logic        fast_link_failure_second_gen,
  input wire logic        te_mode,
  input wire logic        test_packet_generator_lpi,
  input wire logic [15:0] magic_packet_wake_addr_low
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // reversed bit order of a nibble
  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction
  logic wr_hit;
  assign wr_hit = mgmt_valid && mgmt_write && mgmt_hit;
  // a read that hits is answered one cycle later, exactly
  property p_read; mgmt_valid && !mgmt_write && mgmt_hit |=> mgmt_rvalid;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_te; wr_hit && mgmt_reg == REG_ENERGY_CTRL
    |=> te_mode == $past(mgmt_wdata[15]); endproperty
  a_te: assert property (p_te) else $error("te mode not written");
  // inversion field updates one edge after the write, the pins one edge later
  property p_led; wr_hit && mgmt_reg == REG_ENERGY_CTRL ##1 1'b1
    |=> ##1 led_out == (~$past(led_raw) ^ $past(mgmt_wdata[11:10], 3));
  endproperty
  a_led: assert property (p_led) else $error("led polarity wrong");
  property p_force; test_packet_generator_lpi && $past(
    test_packet_generator_lpi) |-> line_tx_lpi && line_txd == 4'h0; endproperty
  a_force: assert property (p_force) else $error("forced lpi lost");
  property p_rxrev; !$past(srst) |-> mac_rxd == $past(line_rxd)
    || mac_rxd == rev4($past(line_rxd)); endproperty
  a_rxrev: assert property (p_rxrev) else $error("rx nibble bad");
  property p_wake; wr_hit && mgmt_reg == REG_WAKE_ADDR_LOW
    |=> magic_packet_wake_addr_low == $past(mgmt_wdata); endproperty
  a_wake: assert property (p_wake) else $error("wake addr bad");
  // a software reset leaves sticky fields alone
  property p_soft; soft_rst && !mgmt_valid |=> $stable(te_mode)
    && $stable(magic_packet_wake_addr_low); endproperty
  a_soft: assert property (p_soft) else $error("sticky lost");
  property p_flf; soft_rst && !mgmt_valid
    |-> ##2 !fast_link_failure_second_gen; endproperty
  a_flf: assert property (p_flf) else $error("fast_link_failure_second_gen kept");
endmodule

// file: verif/test_ext_page2_eee_rgmii_ctrl.sv
// testbench for the page 2 energy, mac interface and wake registers
`timescale 1ns/1ps
module test_ext_page2_eee_rgmii_ctrl;
  import eeprc_pkg::*;
  logic        clk_sys, srst, soft_rst, mgmt_valid, mgmt_write, mgmt_hit;
  logic [4:0]  mgmt_reg;
  logic [15:0] mgmt_wdata, mgmt_rdata, magic_packet_wake_addr_low, q;
  logic        mgmt_rvalid, link_up_in, speed_100_in, eee_negotiated_in;
  logic        mac_tx_lpi, line_tx_lpi, line_rx_lpi, mac_rx_lpi, ok;
  logic        sof_event_in, sof_out, fast_link_failure_second_gen_event_in, te_mode;
  logic        fast_link_failure_second_gen, test_packet_generator_lpi;
  logic [1:0]  led_raw, led_out;
  logic [3:0]  mac_txd, line_txd, line_rxd, mac_rxd;
  logic [2:0]  rx_clk_delay, tx_clk_delay;
  int          mismatches = 0;
  int          checks = 0;
  eeprc_regs eeprc_regs_i (.*);
  eeprc_mgr_model eeprc_mgr_model_i (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    eeprc_mgr_model_i.access(1'b1, r, d, ok, q);
  endtask
  // read must be answered and carry the expected word
  task automatic rd(input logic [4:0] r, input logic [15:0] exp);
    eeprc_mgr_model_i.access(1'b0, r, 16'h0000, ok, q);
    chk({15'h0000, ok}, 16'h0001);
    chk(q, exp);
  endtask
  task automatic t_after_reset();
    chk({14'h0000, led_out}, 16'h0003);
    eeprc_mgr_model_i.access(1'b0, REG_ENERGY_CTRL, 16'h0000, ok, q);
    chk({15'h0000, ok}, 16'h0000);
    eeprc_mgr_model_i.page(PAGE_EXTENDED_TWO);
    rd(REG_ENERGY_CTRL, 16'h0000);
    rd(REG_MAC_IF_CTRL, 16'h0000);
    rd(REG_WAKE_ADDR_LOW, RST_WAKE_ADDR_LOW);
  endtask
  // all ones: only writable bits stick, reserved read zero
  task automatic t_fields();
    wr(REG_ENERGY_CTRL, 16'hffff);
    rd(REG_ENERGY_CTRL, 16'h8c1c);
    chk({14'h0000, te_mode, test_packet_generator_lpi}, 16'h0003);
    chk({11'h000, line_tx_lpi, line_txd}, 16'h0010);
    wr(REG_ENERGY_CTRL, 16'h0000);
    wr(REG_MAC_IF_CTRL, 16'hffff);
    rd(REG_MAC_IF_CTRL, 16'h90ff);
    chk({10'h000, rx_clk_delay, tx_clk_delay}, 16'h003f);
    wr(REG_WAKE_ADDR_LOW, 16'ha5c3);
    rd(REG_WAKE_ADDR_LOW, 16'ha5c3);
    chk(magic_packet_wake_addr_low, 16'ha5c3);
  endtask
  task automatic t_datapath();
    mac_txd = 4'h1;
    line_rxd = 4'h2;
    sof_event_in = 1'b1;
    fast_link_failure_second_gen_event_in = 1'b1;
    led_raw = 2'b01;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({8'h00, line_txd, mac_rxd}, 16'h0084);
    chk({14'h0000, sof_out, fast_link_failure_second_gen}, 16'h0003);
    chk({14'h0000, led_out}, 16'h0002);
  endtask
  // software reset clears only the fast link failure enable
  task automatic t_soft();
    soft_rst = 1'b1;
    @(posedge clk_sys);
    #1;
    soft_rst = 1'b0;
    rd(REG_MAC_IF_CTRL, 16'h10ff);
    rd(REG_WAKE_ADDR_LOW, 16'ha5c3);
    chk({15'h0000, fast_link_failure_second_gen}, 16'h0000);
  endtask
  task automatic t_eee();
    {link_up_in, speed_100_in, eee_negotiated_in} = 3'h7;
    {mac_tx_lpi, line_rx_lpi} = 2'h3;
    wr(REG_ENERGY_CTRL, 16'h0008);
    rd(REG_ENERGY_CTRL, 16'h0148);
    chk({14'h0000, line_tx_lpi, mac_rx_lpi}, 16'h0001);
    wr(REG_ENERGY_CTRL, 16'h0004);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({14'h0000, line_tx_lpi, mac_rx_lpi}, 16'h0002);
  endtask
  // hardware reset returns sticky fields to defaults
  task automatic t_hw_reset();
    srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    eeprc_mgr_model_i.page(PAGE_EXTENDED_TWO);
    rd(REG_WAKE_ADDR_LOW, 16'h0000);
  endtask
  task automatic conclude();
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    srst = 1'b1;
    {soft_rst, link_up_in, speed_100_in, eee_negotiated_in} = 4'h0;
    {mac_tx_lpi, line_rx_lpi, sof_event_in, fast_link_failure_second_gen_event_in} = 4'h0;
    led_raw = 2'b00;
    mac_txd = 4'h0;
    line_rxd = 4'h0;
    repeat (20) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_after_reset();
    t_fields();
    t_datapath();
    t_soft();
    t_eee();
    t_hw_reset();
    conclude();
  end
endmodule
bind eeprc_regs eeprc_regs_sva eeprc_regs_sva_i (.*);
